// ---- hdl/asmc_ctrl.sv ----
// System mode control registers: standby/active, wake and sleep rates,
// oversampling schemes, auto-sleep, self-test and software reset.
// Assumes a serial register interface in front that issues single-cycle
// write and read strobes, and an activity pulse from the detection blocks.
// Contract
// - The sleep rate field decodes 00..11 as 50, 12.5, 6.25 and 1.56 Hz and resets to 00.
// - In auto-sleep the output rate and all block rates follow the sleep rate instead of the wake rate.
// - The output rate field decodes 000..111 as 800 Hz down to 1.56 Hz and resets to 000.
// - Active bit 0 keeps standby, 1 selects active mode, reset value 0.
// - Low-noise mode limits the measurable range to plus or minus 4 g.
// - Fast-read makes the auto-increment pointer skip low data bytes; reset value 0.
// - The self-check bit turns on self-test so the axis outputs shift; reset value 0.
// - Writing 1 to the soft reset bit resets every register to default in any mode.
// - A soft reset also resets the serial communication logic.
// - The soft reset bit clears at end of boot and always reads zero.
// - Each oversampling field decodes as normal, low-noise low-power, high resolution, low power; wake or sleep applies.
// - The averaging ratio depends on scheme and rate, e.g. 1024 for high resolution at 1.56 Hz, 2 for all at 800 Hz.
// - The auto-sleep bit permits automatic sleep when 1 and forbids it when 0; reset value 0.
// - With auto-sleep on, inactivity of the count register times 320 ms (640 ms at 1.56 Hz) moves to the sleep rate.
// - With auto-sleep off, the device only toggles between standby and wake.
`timescale 1ns/100ps
`default_nettype none
module asmc_ctrl
   import asmc_pkg::*;
#(
   parameter int INACT_STEP_CYC = asmc_pkg::ASMC_INACT_STEP_CYC,
   parameter int INACT_STEP_SLOW_CYC = asmc_pkg::ASMC_INACT_STEP_SLOW_CYC
) (
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [7:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   output logic [7:0] reg_rdata, // Read data, registered
   input wire logic [7:0] inactivity_count, // Inactivity count in steps
   input wire logic activity, // Wake or keep-awake event pulse
   output logic serial_rst, // Reset to the serial interface logic
   output logic active_mode, // Device in active mode
   output logic sleeping, // Device in auto-sleep
   output logic [2:0] output_sample_rate, // Effective rate code, output rate encoding
   output logic [1:0] oversample_mode, // Effective oversampling scheme
   output logic [asmc_pkg::ASMC_OSR_W-1:0] oversample_ratio, // Averaging ratio
   output logic low_noise_sel, // Limits range to 4 g
   output logic fast_read, // Pointer skips low data bytes
   output logic self_check_en // Self-test enable
);
   import asmc_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [7:0] ctl1_q, ctl1_d;
   logic [7:0] ctl2_q, ctl2_d;
   asmc_state_t st_q, st_d;
   logic [31:0] step_q, step_d;
   logic [7:0] nstep_q, nstep_d;
   logic [2:0] boot_q, boot_d;
   logic [7:0] rdata_q, rdata_d;
   logic [2:0] rate_q, rate_d;
   logic [1:0] osm_q, osm_d;
   logic [ASMC_OSR_W-1:0] osr_q, osr_d;

   logic wr1, wr2, srst_req, standby_now;
   logic [2:0] slr_odr;
   logic [31:0] step_len;

   assign wr1 = reg_wr && (reg_addr == ASMC_SYSCTL1_ADDR);
   assign wr2 = reg_wr && (reg_addr == ASMC_SYSCTL2_ADDR);
   assign srst_req = wr2 && reg_wdata[ASMC_SRST_BIT];
   assign standby_now = !ctl1_q[ASMC_ACTIVE_BIT];

   // Sleep rate codes map onto output rate codes 100, 101, 110, 111
   assign slr_odr = {1'b1, ctl1_q[ASMC_SLR_LSB +: 2]};

   // Slowest rate uses the doubled inactivity step
   assign step_len = (rate_q == ASMC_ODR_1HZ56) ? INACT_STEP_SLOW_CYC : INACT_STEP_CYC;

   // Averaging ratio by scheme and rate code, kept as a power-of-two shift
   // so the table stays small; every ratio in the set is a power of two
   function automatic logic [ASMC_OSR_W-1:0] os_ratio(input logic [1:0] m, input logic [2:0] r);
      logic [3:0] sh;
      sh = 4'h1;
      unique case (m)
         ASMC_OS_NORMAL: begin
            unique case (r)
               3'h0: sh = 4'h1;
               3'h1: sh = 4'h2;
               3'h2: sh = 4'h2;
               3'h3: sh = 4'h2;
               3'h4: sh = 4'h2;
               3'h5: sh = 4'h4;
               3'h6: sh = 4'h5;
               3'h7: sh = 4'h7;
            endcase
         end
         ASMC_OS_LNLP: begin
            unique case (r)
               3'h0: sh = 4'h1;
               3'h1: sh = 4'h2;
               3'h2: sh = 4'h2;
               3'h3: sh = 4'h2;
               3'h4: sh = 4'h2;
               3'h5: sh = 4'h2;
               3'h6: sh = 4'h3;
               3'h7: sh = 4'h5;
            endcase
         end
         ASMC_OS_HIRES: begin
            unique case (r)
               3'h0: sh = 4'h1;
               3'h1: sh = 4'h2;
               3'h2: sh = 4'h3;
               3'h3: sh = 4'h4;
               3'h4: sh = 4'h5;
               3'h5: sh = 4'h7;
               3'h6: sh = 4'h8;
               3'h7: sh = 4'ha;
            endcase
         end
         ASMC_OS_LOWPWR: begin
            unique case (r)
               3'h0: sh = 4'h1;
               3'h1: sh = 4'h1;
               3'h2: sh = 4'h1;
               3'h3: sh = 4'h1;
               3'h4: sh = 4'h1;
               3'h5: sh = 4'h1;
               3'h6: sh = 4'h2;
               3'h7: sh = 4'h4;
            endcase
         end
      endcase
      return ASMC_OSR_W'(1) << sh;
   endfunction

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      ctl1_d = ctl1_q;
      ctl2_d = ctl2_q;
      st_d = st_q;
      step_d = step_q;
      nstep_d = nstep_q;
      boot_d = boot_q;
      rdata_d = rdata_q;
      if (srst_req) begin
         // Control registers, state, counters and read data back to default, then a short boot
         ctl1_d = ASMC_REG_RESET;
         ctl2_d = ASMC_REG_RESET;
         st_d = ASMC_ST_BOOT;
         boot_d = 3'(ASMC_BOOT_CYC);
         step_d = '0;
         nstep_d = '0;
         rdata_d = '0;
      end else begin
         if (wr1) begin
            if (standby_now) ctl1_d = reg_wdata;
            else ctl1_d[ASMC_ACTIVE_BIT] = reg_wdata[ASMC_ACTIVE_BIT];
         end
         if (wr2) ctl2_d = reg_wdata & ASMC_SYSCTL2_WMASK;
         if (reg_rd) begin
            unique case (reg_addr)
               ASMC_SYSCTL1_ADDR: rdata_d = ctl1_q;
               ASMC_SYSCTL2_ADDR: rdata_d = ctl2_q;
               default: rdata_d = '0;
            endcase
         end
         unique case (st_q)
            ASMC_ST_BOOT: begin
               if (boot_q == 3'h0) st_d = ASMC_ST_STANDBY;
               else boot_d = boot_q - 3'h1;
            end
            ASMC_ST_STANDBY: begin
               step_d = '0;
               nstep_d = '0;
               if (ctl1_d[ASMC_ACTIVE_BIT]) st_d = ASMC_ST_WAKE;
            end
            ASMC_ST_WAKE: begin
               if (!ctl1_d[ASMC_ACTIVE_BIT]) st_d = ASMC_ST_STANDBY;
               else if (activity || !ctl2_q[ASMC_AUTO_SLEEP_EN_BIT]) begin
                  step_d = '0;
                  nstep_d = '0;
               end else if (nstep_q >= inactivity_count) begin
                  st_d = ASMC_ST_SLEEP;
               end else if (step_q + 32'h1 >= step_len) begin
                  step_d = '0;
                  nstep_d = nstep_q + 8'h1;
               end else begin
                  step_d = step_q + 32'h1;
               end
            end
            ASMC_ST_SLEEP: begin
               step_d = '0;
               nstep_d = '0;
               if (!ctl1_d[ASMC_ACTIVE_BIT]) st_d = ASMC_ST_STANDBY;
               else if (activity || !ctl2_q[ASMC_AUTO_SLEEP_EN_BIT]) st_d = ASMC_ST_WAKE;
            end
         endcase
      end
   end

   // Effective rate and scheme, registered for clean outputs
   always_comb begin
      if (st_q == ASMC_ST_SLEEP) begin
         rate_d = slr_odr;
         osm_d = ctl2_q[ASMC_SOS_LSB +: 2];
      end else begin
         rate_d = ctl1_q[ASMC_ODR_LSB +: 3];
         osm_d = ctl2_q[ASMC_WOS_LSB +: 2];
      end
      osr_d = os_ratio(osm_d, rate_d);
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctl1_q <= ASMC_REG_RESET;
         ctl2_q <= ASMC_REG_RESET;
         st_q <= ASMC_ST_BOOT;
         step_q <= '0;
         nstep_q <= '0;
         boot_q <= 3'(ASMC_BOOT_CYC);
         rdata_q <= '0;
         rate_q <= '0;
         osm_q <= '0;
         osr_q <= ASMC_OSR_W'(2);
      end else if (clk_en) begin
         ctl1_q <= ctl1_d;
         ctl2_q <= ctl2_d;
         st_q <= st_d;
         step_q <= step_d;
         nstep_q <= nstep_d;
         boot_q <= boot_d;
         rdata_q <= rdata_d;
         rate_q <= rate_d;
         osm_q <= osm_d;
         osr_q <= osr_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Serial logic is held in reset through the whole boot
   assign serial_rst = (st_q == ASMC_ST_BOOT);
   assign active_mode = (st_q == ASMC_ST_WAKE) || (st_q == ASMC_ST_SLEEP);
   assign sleeping = (st_q == ASMC_ST_SLEEP);
   assign output_sample_rate = rate_q;
   assign oversample_mode = osm_q;
   assign oversample_ratio = osr_q;
   assign low_noise_sel = ctl1_q[ASMC_LOW_NOISE_SEL_BIT];
   assign fast_read = ctl1_q[ASMC_FREAD_BIT];
   assign self_check_en = ctl2_q[ASMC_SELF_BIT];
   assign reg_rdata = rdata_q;

endmodule // asmc_ctrl
`default_nettype wire

// ---- hdl/asmc_pkg.sv ----
// Package for the accelerometer system mode control register bank.
// Assumes a register access port that presents byte-wide address and data.
package asmc_pkg;
   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ASMC_SYSCTL1_ADDR = 8'h2a;
   localparam logic [7:0] ASMC_SYSCTL2_ADDR = 8'h2b;
   localparam logic [7:0] ASMC_REG_RESET = 8'h00;
   // Field positions of the first control register
   localparam int ASMC_ACTIVE_BIT = 0;
   localparam int ASMC_FREAD_BIT = 1;
   localparam int ASMC_LOW_NOISE_SEL_BIT = 2;
   localparam int ASMC_ODR_LSB = 3;
   localparam int ASMC_SLR_LSB = 6;
   // Field positions of the second control register
   localparam int ASMC_WOS_LSB = 0;
   localparam int ASMC_AUTO_SLEEP_EN_BIT = 2;
   localparam int ASMC_SOS_LSB = 3;
   localparam int ASMC_SRST_BIT = 6;
   localparam int ASMC_SELF_BIT = 7;
   localparam logic [7:0] ASMC_SYSCTL2_WMASK = 8'h9f;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int ASMC_CLK_MHZ = 100;
   localparam int ASMC_INACT_STEP_MS = 320;
   localparam int ASMC_INACT_STEP_SLOW_MS = 640;
   localparam int ASMC_INACT_STEP_CYC = ASMC_INACT_STEP_MS * 1000 * ASMC_CLK_MHZ;
   localparam int ASMC_INACT_STEP_SLOW_CYC = ASMC_INACT_STEP_SLOW_MS * 1000 * ASMC_CLK_MHZ;
   localparam int ASMC_BOOT_CYC = 4;
   // Rate codes
   localparam logic [2:0] ASMC_ODR_1HZ56 = 3'h7;
   localparam logic [1:0] ASMC_SLR_50HZ = 2'h0;
   // Oversampling schemes
   typedef enum logic [1:0] {
      ASMC_OS_NORMAL = 2'h0,
      ASMC_OS_LNLP = 2'h1,
      ASMC_OS_HIRES = 2'h2,
      ASMC_OS_LOWPWR = 2'h3
   } asmc_os_t;
   // Operating states
   typedef enum logic [3:0] {
      ASMC_ST_BOOT = 4'h1,
      ASMC_ST_STANDBY = 4'h2,
      ASMC_ST_WAKE = 4'h4,
      ASMC_ST_SLEEP = 4'h8
   } asmc_state_t;
   localparam int ASMC_OSR_W = 11;
endpackage

// ---- testbench/asmc_ctrl_props.sv ----
// Port checker for the system mode control bank.
// Assumes clk_en stays high while a boot sequence runs.
`timescale 1ns/100ps
`default_nettype none
module asmc_ctrl_props
   import asmc_pkg::*;
(
   input wire logic clk_sys, // Clock
   input wire logic arst_n, // Reset, active low
   input wire logic clk_en, // Clock enable
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_addr, // Address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic serial_rst, // Serial reset
   input wire logic active_mode, // Active
   input wire logic sleeping, // Asleep
   input wire logic [2:0] output_sample_rate, // Rate code
   input wire logic [ASMC_OSR_W-1:0] oversample_ratio, // Ratio
   input wire logic low_noise_sel, // Low noise
   input wire logic fast_read, // Fast read
   input wire logic self_check_en // Self test
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Writes during boot still land, but active_mode stays low until the boot ends, so they are left out
   wire wr1 = reg_wr && clk_en && reg_addr == ASMC_SYSCTL1_ADDR && !serial_rst;
   wire wr2 = reg_wr && clk_en && reg_addr == ASMC_SYSCTL2_ADDR && !serial_rst;
   rst_bit_zero_a: assert property (reg_rd && clk_en && reg_addr == ASMC_SYSCTL2_ADDR |=> !reg_rdata[6])
      else $error("soft reset bit read back as one");
   soft_reset_a: assert property (wr2 && reg_wdata[6] |=> serial_rst && !active_mode)
      else $error("soft reset write did not reset");
   boot_end_a: assert property (serial_rst |-> ##[1:8] !serial_rst)
      else $error("boot did not finish");
   active_bit_a: assert property (wr1 |=> active_mode == $past(reg_wdata[0]))
      else $error("active mode does not follow written bit");
   active_hold_a: assert property (wr1 && active_mode |=> $stable(low_noise_sel) && $stable(fast_read))
      else $error("field changed while active");
   standby_fields_a: assert property (wr1 && !active_mode |=>
      low_noise_sel == $past(reg_wdata[2]) && fast_read == $past(reg_wdata[1]))
      else $error("standby write not applied");
   self_check_a: assert property (wr2 && !reg_wdata[6] |=> self_check_en == $past(reg_wdata[7]))
      else $error("self check bit not applied");
   sleep_rate_a: assert property (sleeping [*3] |-> active_mode && output_sample_rate[2])
      else $error("sleep not at sleep rate");
   fast_ratio_a: assert property ((output_sample_rate == 3'h0) [*3] |-> oversample_ratio == 11'h002)
      else $error("ratio at fastest rate not two");
endmodule // asmc_ctrl_props
bind asmc_ctrl asmc_ctrl_props u_props (.clk_sys, .arst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata, .serial_rst, .active_mode, .sleeping, .output_sample_rate, .oversample_ratio, .low_noise_sel,
   .fast_read, .self_check_en);
`default_nettype wire

// ---- testbench/asmc_host.sv ----
// Host model on the register strobe interface.
// Assumes the bank takes a strobe on the rising edge it is high.
`timescale 1ns/100ps
`default_nettype none
module asmc_host (
   input wire logic clk_sys, // Clock
   output logic reg_wr, // Write strobe
   output logic reg_rd, // Read strobe
   output logic [7:0] reg_addr, // Address
   output logic [7:0] reg_wdata // Write data
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // One strobe cycle; released lines show the inverse so stale data never looks valid
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk_sys);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule // asmc_host
`default_nettype wire

// ---- testbench/tb.sv ----
// Testbench for the system mode control bank.
// Assumes the host model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import asmc_pkg::*;
   logic clk_sys, arst_n, clk_en, activity, reg_wr, reg_rd, serial_rst, active_mode, sleeping;
   logic low_noise_sel, fast_read, self_check_en, rd_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, inactivity_count, d;
   logic [2:0] output_sample_rate;
   logic [1:0] oversample_mode;
   logic [ASMC_OSR_W-1:0] oversample_ratio;
   logic [7:0] exp_q[$];
   int num_errors = 0;
   int total_checks = 0;
   int seed = 32'h4114;
   logic [10:0] os_tab [4][8] = '{'{2, 4, 4, 4, 4, 16, 32, 128}, '{2, 4, 4, 4, 4, 4, 8, 32},
      '{2, 4, 8, 16, 32, 128, 256, 1024}, '{2, 2, 2, 2, 2, 2, 4, 16}};
   asmc_host host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
   asmc_ctrl #(.INACT_STEP_CYC(10), .INACT_STEP_SLOW_CYC(20)) uut (.clk_sys, .arst_n, .clk_en, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .inactivity_count, .activity, .serial_rst, .active_mode, .sleeping,
      .output_sample_rate, .oversample_mode, .oversample_ratio, .low_noise_sel, .fast_read, .self_check_en);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic waitv(input logic sel, input logic v);
      int n;
      n = 0;
      while ((sel ? sleeping : serial_rst) !== v && n < 2000) begin
         tick(1);
         n++;
      end
      if ((sel ? sleeping : serial_rst) !== v) begin
         num_errors++;
         final_report();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask
   // ------------------------------------------------------------
   // Read data monitor: one registered answer per read strobe
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      rd_q <= reg_rd && clk_en;
      if (rd_q && exp_q.size() > 0)
         chk(reg_rdata, exp_q.pop_front());
   end
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      activity = 1'b0;
      inactivity_count = 8'h02;
      repeat (20) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      waitv(1'b0, 1'b0);
      chk(oversample_ratio, 11'h002);
      rd(ASMC_SYSCTL1_ADDR, 8'h00);
      rd(ASMC_SYSCTL2_ADDR, 8'h00);
      rd(8'h17, 8'h00);
      for (int r = 0; r < 8; r++) begin
         for (int s = 0; s < 4; s++) begin
            d = {2'(s), 3'(r), 2'($random(seed)), 1'b0};
            host.xfer(1'b1, ASMC_SYSCTL1_ADDR, d);
            host.xfer(1'b1, ASMC_SYSCTL2_ADDR, {6'h00, 2'(s)});
            tick(3);
            chk(output_sample_rate, 11'(r));
            chk(oversample_mode, 11'(s));
            chk(oversample_ratio, os_tab[s][r]);
            chk({low_noise_sel, fast_read}, 11'(d[2:1]));
            rd(ASMC_SYSCTL1_ADDR, d);
         end
      end
      clk_en = 1'b0;
      host.xfer(1'b1, ASMC_SYSCTL1_ADDR, 8'h28);
      tick(2);
      chk(output_sample_rate, 11'h007);
      clk_en = 1'b1;
      tick(2);
      chk(output_sample_rate, 11'h007);
      host.xfer(1'b1, ASMC_SYSCTL1_ADDR, 8'h81);
      tick(1);
      chk(active_mode, 1'b1);
      host.xfer(1'b1, ASMC_SYSCTL1_ADDR, 8'h2f);
      rd(ASMC_SYSCTL1_ADDR, 8'h81);
      host.xfer(1'b1, ASMC_SYSCTL2_ADDR, 8'h95);
      waitv(1'b1, 1'b1);
      tick(3);
      chk(output_sample_rate, 11'h006);
      chk(oversample_mode, 11'h002);
      chk(oversample_ratio, 11'h100);
      chk(self_check_en, 1'b1);
      rd(ASMC_SYSCTL2_ADDR, 8'h95);
      activity = 1'b1;
      waitv(1'b1, 1'b0);
      host.xfer(1'b1, ASMC_SYSCTL2_ADDR, 8'h01);
      activity = 1'b0;
      tick(100);
      chk(sleeping, 1'b0);
      chk(output_sample_rate, 11'h000);
      host.xfer(1'b1, ASMC_SYSCTL2_ADDR, 8'h40);
      tick(1);
      chk(serial_rst, 1'b1);
      chk(active_mode, 1'b0);
      waitv(1'b0, 1'b0);
      rd(ASMC_SYSCTL1_ADDR, 8'h00);
      rd(ASMC_SYSCTL2_ADDR, 8'h00);
      tick(3);
      final_report();
   end
endmodule // tb
`default_nettype wire
